// ### rtl/afc_defs.svh
`ifndef AFC_DEFS_SVH
`define AFC_DEFS_SVH
// register map and field layout
`define AFC_CONF_OFFSET    8'hAC
`define AFC_HIGH_MSB       23
`define AFC_HIGH_LSB       16
`define AFC_LOW_MSB        15
`define AFC_LOW_LSB        8
`define AFC_DUR_MSB        7
`define AFC_DUR_LSB        4
`define AFC_MULT_BIT       3
`define AFC_BRD_BIT        2
`define AFC_ADDR_BIT       1
`define AFC_ANY_BIT        0
`define AFC_CONF_RESET     32'h0000_0000
`define AFC_CONF_WMASK     32'h00FF_FFFF
// fill level unit is 64 bytes: level in units = bytes >> 6
`define AFC_UNIT_SHIFT     6
// clock and jam timing, times in nanoseconds
`define AFC_CLK_NS         40
`define AFC_JAM_STEP_NS    50000
`define AFC_JAM_10M_ADD_NS 2200
`endif

// ### rtl/afc_pkg.sv
package afc_pkg;
  // controller state, one-hot
  typedef enum logic [2:0] {
    AFC_IDLE   = 3'b001,
    AFC_PAUSED = 3'b010,
    AFC_JAM    = 3'b100
  } afc_state_e;
  // received frame classification from the MAC
  typedef struct packed {
    logic start;    // valid preamble seen, one-cycle pulse
    logic hdr;      // address decoded, one-cycle pulse
    logic mcast;
    logic bcast;
    logic ucast_me;
  } afc_rx_s;
  // all state of the controller
  typedef struct packed {
    afc_state_e  st;
    logic [23:0] cfg;
    logic        pause_req;
    logic        pause_zero;
    logic        paused;
    logic        jam;
    logic [15:0] jam_cnt;
    logic [31:0] rdata;
  } afc_st_s;
endpackage

// ### rtl/afc_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
`include "afc_defs.svh"
// How it works
// [RULE_01] trigger when fill reaches high level*64 bytes
// [RULE_02] full duplex: send one pause at high level
// [RULE_03] half duplex: jam matching frames for duration
// [RULE_04] below low level: send zero-time pause
// [RULE_05] zero pause only after pause was sent
// [RULE_06] zero pause active when any select set
// [RULE_07] host keeps low level below high level
// [RULE_08] duration field sets jam time, half only
// [RULE_09] multicast select jams multicast frames
// [RULE_10] broadcast select jams broadcast frames
// [RULE_11] address select jams frames for us
// [RULE_12] nothing sent while transmitter disabled
// [RULE_13] any-frame select overrides, enables full duplex
// [RULE_14] any-frame: jam on preamble, pause immediately
// [RULE_15] duration codes map to table microseconds
// [RULE_16] pause request held until acknowledged
// [RULE_17] reset clears config and paused state
module afc_ctrl #(
  parameter int FILL_W = 14
) (
  input  wire logic                 sys_clk,
  input  wire logic                 rst_n,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  input  wire logic [7:0]           reg_addr,
  input  wire logic [31:0]          reg_wdata,
  output logic [31:0]               reg_rdata,
  input  wire logic [FILL_W-1:0]    rx_fill_bytes,
  input  wire logic                 full_duplex,
  input  wire logic                 speed_100,
  input  wire logic                 tx_enable,
  input  wire afc_pkg::afc_rx_s     rx_info,
  output logic                      pause_req,
  output logic                      pause_zero,
  input  wire logic                 pause_ack,
  output logic                      jam_out,
  output logic                      paused
);
  // jam timing in sys_clk cycles; the slow-link extra is rounded up so a
  // 10 Mb/s link never gets a shorter jam than asked for; at 40 ns it
  // divides exactly, so no rounding happens at the default clock
  localparam int unsigned STEP_CYC = `AFC_JAM_STEP_NS / `AFC_CLK_NS;       // 50 us
  localparam int unsigned ADD_CYC  = (`AFC_JAM_10M_ADD_NS + `AFC_CLK_NS - 1)
                                     / `AFC_CLK_NS;                          // 2.2 us
  localparam int unsigned FIVE_CYC = STEP_CYC / 10;                          // 5 us

  // every register of the block lives in q, so reset and update sit in one place
  afc_pkg::afc_st_s q, d;          // registered state and its next value
  logic [7:0]       fill_units;    // fill in 64-byte units
  logic             hi_hit;        // level reached
  logic             lo_under;      // level dropped below low
  logic             any_sel;       // any selection enabled
  logic             match;         // incoming frame meets criteria
  logic [15:0]      jam_len;       // jam length in cycles

  // saturate fill to 8 bits of units so large FIFOs still compare
  // a FIFO deeper than 255 units reads as full scale, which still meets any
  // 8-bit high level and is never under a low level, so no compare changes
  always_comb begin
    if ((rx_fill_bytes >> `AFC_UNIT_SHIFT) > FILL_W'(8'hFF)) begin
      fill_units = 8'hFF;
    end else begin
      fill_units = 8'((rx_fill_bytes >> `AFC_UNIT_SHIFT));
    end
  end

  // levels compare in whole units; a partly filled unit does not count
  // a high level of zero leaves the trigger armed all the time
  assign hi_hit   = fill_units >= q.cfg[`AFC_HIGH_MSB:`AFC_HIGH_LSB];  // [RULE_01]
  assign lo_under = fill_units <  q.cfg[`AFC_LOW_MSB:`AFC_LOW_LSB];    // [RULE_04]
  assign any_sel  = |q.cfg[`AFC_MULT_BIT:`AFC_ANY_BIT];            // [RULE_06]

  // frame selection; any-frame acts on preamble, others on decoded header
  // the class qualifiers only mean something in the cycle of the header pulse
  always_comb begin
    if (q.cfg[`AFC_ANY_BIT]) begin
      match = rx_info.start;                                        // [RULE_13] [RULE_14]
    end else begin
      match = rx_info.hdr &                                         // [RULE_09] [RULE_10] [RULE_11]
              ((q.cfg[`AFC_MULT_BIT] & rx_info.mcast) |
               (q.cfg[`AFC_BRD_BIT]  & rx_info.bcast) |
               (q.cfg[`AFC_ADDR_BIT] & rx_info.ucast_me));
    end
  end

  // duration code to cycles: 5,10,15,25 us then 50 us steps
  // read live, so a rewrite during a jam only affects the next jam
  always_comb begin
    logic [3:0] code;
    code = q.cfg[`AFC_DUR_MSB:`AFC_DUR_LSB];
    case (code)                                                     // [RULE_15]
      4'h0:    jam_len = 16'(FIVE_CYC);
      4'h1:    jam_len = 16'(2 * FIVE_CYC);
      4'h2:    jam_len = 16'(3 * FIVE_CYC);
      4'h3:    jam_len = 16'(5 * FIVE_CYC);
      default: jam_len = 16'((32'(code) - 32'd3) * STEP_CYC);
    endcase
    if (!speed_100) begin
      jam_len = jam_len + 16'(ADD_CYC);                             // [RULE_15]
    end
  end

  // next-state logic
  always_comb begin
    d = q;
    d.rdata = 32'h0000_0000;
    // register read: only the config word is mapped, rest reads zero
    if (reg_rd && reg_addr == `AFC_CONF_OFFSET) begin
      d.rdata = {8'h00, q.cfg};
    end
    // reserved top byte is never stored, so it always reads back as zero
    if (reg_wr && reg_addr == `AFC_CONF_OFFSET) begin
      d.cfg = 24'(reg_wdata & `AFC_CONF_WMASK);
    end
    // request held until the MAC accepts it
    // the remembered pause follows the kind of frame the MAC took
    if (q.pause_req && pause_ack) begin                              // [RULE_16]
      d.pause_req = 1'b0;
      if (q.pause_zero) begin
        d.paused = 1'b0;                                            // [RULE_05]
      end else begin
        d.paused = 1'b1;                                            // [RULE_05]
      end
    end
    case (q.st)
      afc_pkg::AFC_IDLE: begin
        d.jam = 1'b0;
        if (!tx_enable || !any_sel) begin
          // stay quiet while transmitter off or feature disabled
        end else if (full_duplex) begin
          // full duplex: only any-frame enables pause; one per crossing
          if (q.cfg[`AFC_ANY_BIT] && hi_hit && !q.paused && !q.pause_req) begin  // [RULE_02] [RULE_12]
            d.pause_req  = 1'b1;
            d.pause_zero = 1'b0;
            d.st         = afc_pkg::AFC_PAUSED;
          end
        end else if (hi_hit && match) begin                         // [RULE_03] [RULE_12]
          d.jam     = 1'b1;
          d.jam_cnt = jam_len;                                      // [RULE_08]
          d.st      = afc_pkg::AFC_JAM;
        end
        // zero pause once level drops after a pause was sent
        // checked in either duplex: a link that fell back to half duplex
        // still needs the remote end released
        if (tx_enable && any_sel && q.paused && !q.pause_req && lo_under) begin  // [RULE_04]
          d.pause_req  = 1'b1;
          d.pause_zero = 1'b1;
        end
      end
      afc_pkg::AFC_PAUSED: begin
        // wait for the pause to go out, then fall back to idle
        if (!q.pause_req) begin
          d.st = afc_pkg::AFC_IDLE;
        end
      end
      afc_pkg::AFC_JAM: begin
        // transmitter off cuts the jam short
        // matches during a jam are ignored; the jam is never stretched
        if (!tx_enable || q.jam_cnt <= 16'h0001) begin               // [RULE_12] [RULE_08]
          d.jam     = 1'b0;
          d.jam_cnt = 16'h0000;
          d.st      = afc_pkg::AFC_IDLE;
        end else begin
          d.jam_cnt = q.jam_cnt - 16'h0001;
        end
      end
      default: d.st = afc_pkg::AFC_IDLE;
    endcase
  end

  // state register; reset clears config and remembered pause
  // synchronous reset: nothing clears between clock edges
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      q.st         <= afc_pkg::AFC_IDLE;
      q.cfg        <= 24'(`AFC_CONF_RESET);                          // [RULE_17]
      q.pause_req  <= 1'b0;
      q.pause_zero <= 1'b0;
      q.paused     <= 1'b0;                                         // [RULE_17]
      q.jam        <= 1'b0;
      q.jam_cnt    <= 16'h0000;
      q.rdata      <= 32'h0000_0000;
    end else begin
      q <= d;
    end
  end

  // every output is a register bit; nothing combinational leaves the block
  assign reg_rdata  = q.rdata;
  assign pause_req  = q.pause_req;
  assign pause_zero = q.pause_zero;
  assign jam_out    = q.jam;
  assign paused     = q.paused;

  // jam never starts with transmitter off
  AST_NO_JAM_TX_OFF: assert property (@(posedge sys_clk) disable iff (!rst_n)  // [RULE_12]
    (!tx_enable && !q.jam) |=> !q.jam) else $error("jam started with tx off");
  // request stays until acknowledged
  AST_REQ_HELD: assert property (@(posedge sys_clk) disable iff (!rst_n)  // [RULE_16]
    (q.pause_req && !pause_ack) |=> q.pause_req) else $error("pause request dropped");
  // zero pause only when paused
  AST_ZERO_AFTER_PAUSE: assert property (@(posedge sys_clk) disable iff (!rst_n)  // [RULE_05]
    $rose(q.pause_req) && q.pause_zero |-> q.paused) else $error("zero pause unpaused");
  // full-duplex pause only once until zero pause
  AST_ONE_PAUSE: assert property (@(posedge sys_clk) disable iff (!rst_n)  // [RULE_02]
    $rose(q.pause_req) && !q.pause_zero |-> !q.paused) else $error("second pause");
  // ack of a normal pause sets paused
  AST_PAUSED_SET: assert property (@(posedge sys_clk) disable iff (!rst_n)  // [RULE_05]
    (q.pause_req && pause_ack && !q.pause_zero) |=> q.paused) else $error("paused not set");
  // jam starts with duration loaded
  AST_JAM_LOAD: assert property (@(posedge sys_clk) disable iff (!rst_n)  // [RULE_08]
    $rose(q.jam) |-> q.jam_cnt == $past(jam_len)) else $error("bad jam length");
  // no jam starts in full duplex
  AST_NO_JAM_FD: assert property (@(posedge sys_clk) disable iff (!rst_n)  // [RULE_03]
    (full_duplex && !q.jam) |=> !q.jam) else $error("jam in full duplex");
  // no action with all selects clear
  AST_OFF_QUIET: assert property (@(posedge sys_clk) disable iff (!rst_n)  // [RULE_06]
    (!any_sel && !q.pause_req && !q.jam) |=> !$rose(q.pause_req) && !$rose(q.jam))
    else $error("action while disabled");

  // checks below watch the registered state and the inputs from the MAC;
  // all but the reset check are held off while reset is applied
  // jam only starts once the level is reached
  AST_JAM_NEEDS_HI: assert property (@(posedge sys_clk) disable iff (!rst_n)  // [RULE_01]
    $rose(q.jam) |-> $past(hi_hit))
    else $error("jam below high level");
  // normal pause only once the level is reached
  AST_PAUSE_NEEDS_HI: assert property (@(posedge sys_clk) disable iff (!rst_n)  // [RULE_01]
    ($rose(q.pause_req) && !q.pause_zero) |-> $past(hi_hit))
    else $error("pause below high level");
  // normal pause only in full duplex
  AST_PAUSE_FD_ONLY: assert property (@(posedge sys_clk) disable iff (!rst_n)  // [RULE_02]
    ($rose(q.pause_req) && !q.pause_zero) |-> $past(full_duplex))
    else $error("pause in half duplex");
  // jam only for a matching frame in half duplex
  AST_JAM_HD_MATCH: assert property (@(posedge sys_clk) disable iff (!rst_n)  // [RULE_03]
    $rose(q.jam) |-> $past(match) && !$past(full_duplex))
    else $error("jam without match");
  // no jam while in the pausing state (a normal pause outstanding)
  AST_NO_JAM_PAUSED: assert property (@(posedge sys_clk) disable iff (!rst_n)  // [RULE_03]
    (q.st == afc_pkg::AFC_PAUSED) |-> !q.jam)
    else $error("jam while pausing");
  // zero pause only below the low level
  AST_ZERO_NEEDS_LOW: assert property (@(posedge sys_clk) disable iff (!rst_n)  // [RULE_04]
    ($rose(q.pause_req) && q.pause_zero) |-> $past(lo_under))
    else $error("zero pause above low level");
  // accepted zero pause clears the remembered pause
  AST_ZERO_CLEARS: assert property (@(posedge sys_clk) disable iff (!rst_n)  // [RULE_05]
    (q.pause_req && pause_ack && q.pause_zero) |=> !q.paused)
    else $error("paused not cleared");
  // zero pause only with a selection enabled
  AST_ZERO_NEEDS_SEL: assert property (@(posedge sys_clk) disable iff (!rst_n)  // [RULE_06]
    ($rose(q.pause_req) && q.pause_zero) |-> $past(any_sel))
    else $error("zero pause while disabled");
  // jam counter steps down by one each cycle
  AST_JAM_COUNTS: assert property (@(posedge sys_clk) disable iff (!rst_n)  // [RULE_08]
    (q.jam && tx_enable && q.jam_cnt > 16'h0001) |=> q.jam && (q.jam_cnt == $past(q.jam_cnt) - 16'h0001))
    else $error("jam count skipped");
  // jam ends when the count runs out
  AST_JAM_ENDS: assert property (@(posedge sys_clk) disable iff (!rst_n)  // [RULE_08]
    (q.jam && q.jam_cnt <= 16'h0001) |=> !q.jam)
    else $error("jam overran");
  // without any-frame, a jam needs a header of a selected class
  AST_JAM_CLASS: assert property (@(posedge sys_clk)  // [RULE_09] [RULE_10] [RULE_11]
    disable iff (!rst_n)
    ($rose(q.jam) && !$past(q.cfg[`AFC_ANY_BIT])) |->
      $past(rx_info.hdr & ((q.cfg[`AFC_MULT_BIT] & rx_info.mcast) |
                           (q.cfg[`AFC_BRD_BIT] & rx_info.bcast) |
                           (q.cfg[`AFC_ADDR_BIT] & rx_info.ucast_me))))
    else $error("jam for unselected frame");
  // no pause request starts with transmitter off
  AST_NO_PAUSE_TX_OFF: assert property (@(posedge sys_clk) disable iff (!rst_n)  // [RULE_12]
    (!tx_enable && !q.pause_req) |=> !q.pause_req)
    else $error("pause with tx off");
  // transmitter off ends a running jam
  AST_JAM_TX_CUT: assert property (@(posedge sys_clk) disable iff (!rst_n)  // [RULE_12]
    (q.jam && !tx_enable) |=> !q.jam)
    else $error("jam kept with tx off");
  // normal pause only with any-frame select
  AST_PAUSE_NEEDS_ANY: assert property (@(posedge sys_clk) disable iff (!rst_n)  // [RULE_13]
    ($rose(q.pause_req) && !q.pause_zero) |-> $past(q.cfg[`AFC_ANY_BIT]))
    else $error("pause without any-frame");
  // any-frame jam starts on a preamble
  AST_ANY_ON_PREAMBLE: assert property (@(posedge sys_clk) disable iff (!rst_n)  // [RULE_14]
    ($rose(q.jam) && $past(q.cfg[`AFC_ANY_BIT])) |-> $past(rx_info.start))
    else $error("any-frame jam without preamble");
  // loaded length lies inside the duration table
  AST_JAM_RANGE: assert property (@(posedge sys_clk) disable iff (!rst_n)  // [RULE_15]
    $rose(q.jam) |-> (q.jam_cnt >= 16'(FIVE_CYC)) && (q.jam_cnt <= 16'(12 * STEP_CYC + ADD_CYC)))
    else $error("jam length out of table");
  // acknowledge drops the request next cycle
  AST_ACK_DROPS: assert property (@(posedge sys_clk) disable iff (!rst_n)  // [RULE_16]
    (q.pause_req && pause_ack) |=> !q.pause_req)
    else $error("request kept after ack");
  // kind of pause holds with its request
  AST_KIND_HELD: assert property (@(posedge sys_clk) disable iff (!rst_n)  // [RULE_16]
    (q.pause_req && !pause_ack) |=> $stable(q.pause_zero))
    else $error("pause kind changed");
  // pausing state returns to idle once the request is taken
  AST_PAUSED_RETURNS: assert property (@(posedge sys_clk) disable iff (!rst_n)  // [RULE_02]
    (q.st == afc_pkg::AFC_PAUSED && !q.pause_req) |=> (q.st == afc_pkg::AFC_IDLE))
    else $error("stuck in pausing state");
  // state stays one-hot
  AST_STATE_ONEHOT: assert property (@(posedge sys_clk) disable iff (!rst_n)  // [RULE_03]
    $onehot(q.st))
    else $error("state not one-hot");
  // reset clears config, pause memory, pause request and jam
  AST_RESET_CLEARS: assert property (@(posedge sys_clk)  // [RULE_17]
    !rst_n |=> (q.cfg == 24'h00_0000) && !q.paused && !q.pause_req && !q.jam)
    else $error("reset left state behind");
endmodule
`default_nettype wire

// ### verif/afc_mac_model.sv
`timescale 1ns/100ps
`default_nettype none
// transmitter side: takes a pause request after a queueing delay
module afc_mac_model #(
  parameter int ACK_DLY = 3
) (
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic pause_req,
  output logic      pause_ack
);
  int cnt; // cycles the request has waited
  // one ack pulse after the delay; a request still high then starts a new count
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cnt       <= 0;
      pause_ack <= 1'b0;
    end else if (pause_ack) begin
      cnt       <= 0;
      pause_ack <= 1'b0;
    end else if (pause_req) begin
      cnt       <= cnt + 1;
      pause_ack <= (cnt == ACK_DLY);
    end else begin
      cnt <= 0;
    end
  end
endmodule
`default_nettype wire

// ### verif/rx_fifo_auto_flow_control_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module rx_fifo_auto_flow_control_tb_top;
  logic sys_clk, rst_n, reg_wr, reg_rd, full_duplex, speed_100, tx_enable;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rd;
  logic [13:0] rx_fill_bytes;
  afc_pkg::afc_rx_s rx_info;
  logic pause_req, pause_zero, pause_ack, jam_out, paused;
  int n_errors = 0;
  int tests_run = 0;
  int k;
  // jam length rows: duration code, speed, expected cycles
  typedef struct packed {logic [3:0] code; logic spd; logic [15:0] len;} afc_row_s;
  afc_row_s rows [7] = '{'{4'h0, 1'b1, 16'h007D}, '{4'h0, 1'b0, 16'h00B4},
    '{4'h1, 1'b1, 16'h00FA}, '{4'h3, 1'b1, 16'h0271}, '{4'h4, 1'b1, 16'h04E2},
    '{4'h5, 1'b0, 16'h09FB}, '{4'hF, 1'b1, 16'h3A98}};
  afc_ctrl afc_ctrl_i (.sys_clk(sys_clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .rx_fill_bytes(rx_fill_bytes), .full_duplex(full_duplex), .speed_100(speed_100),
    .tx_enable(tx_enable), .rx_info(rx_info), .pause_req(pause_req),
    .pause_zero(pause_zero), .pause_ack(pause_ack), .jam_out(jam_out), .paused(paused));
  afc_mac_model afc_mac_model_i (.sys_clk(sys_clk), .rst_n(rst_n), .pause_req(pause_req),
    .pause_ack(pause_ack));
  // 25 MHz
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  // inputs always move 1 ns after the edge
  task automatic tick();
    @(posedge sys_clk);
    #1;
  endtask
  task automatic wrap_up();
    if (n_errors == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s exp %h got %h", nm, exp, got);
    end
  endtask
  // bounded wait for pause_req (w=0) or jam_out (w=1)
  task automatic await_hi(input logic w);
    for (int i = 0; i < 50; i++) begin
      if ((w ? jam_out : pause_req) === 1'b1) return;
      tick();
    end
    chk("await", 32'h1, 32'h0);
    wrap_up();
  endtask
  // extra tick keeps strobes from toggling twice in one step
  task automatic wr(input logic [31:0] d, input logic [7:0] a = 8'hAC);
    reg_wr = 1'b1; reg_addr = a; reg_wdata = d;
    tick();
    reg_wr = 1'b0;
    tick();
  endtask
  task automatic rdr(input logic [7:0] a);
    reg_rd = 1'b1; reg_addr = a;
    tick();
    reg_rd = 1'b0; rd = reg_rdata;
    tick();
  endtask
  // one header or preamble pulse, then look for back pressure
  task automatic jtry(input logic [3:0] sel, input logic [4:0] info, input logic exp);
    wr({16'h0001, 12'h000, sel});
    rx_info = afc_pkg::afc_rx_s'(info);
    tick();
    rx_info = '0;
    tick();
    chk("jam_sel", {31'h0, exp}, {31'h0, jam_out});
    repeat (130) tick();
  endtask
  initial begin
    rst_n = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 8'h00; reg_wdata = 32'h0;
    rx_fill_bytes = 14'h0000; full_duplex = 1'b0; speed_100 = 1'b1; tx_enable = 1'b1;
    rx_info = '0;
    repeat (20) tick();
    rst_n = 1'b1;
    rdr(8'hAC); chk("cfg_rst", 32'h0, rd);
    chk("out_rst", 32'h0, {pause_req, jam_out, paused});
    wr(32'hFFFFFFFF); rdr(8'hAC); chk("cfg_rw", 32'h00FFFFFF, rd);
    wr(32'h0, 8'hA8); rdr(8'hA8); chk("unmapped", 32'h0, rd);
    rdr(8'hAC); chk("cfg_keep", 32'h00FFFFFF, rd);
    // half duplex jam lengths, fill exactly at one 64-byte unit
    rx_fill_bytes = 14'h0040;
    foreach (rows[i]) begin
      speed_100 = rows[i].spd;
      wr({16'h0001, 8'h00, rows[i].code, 4'h4});
      rx_info.hdr = 1'b1; rx_info.bcast = 1'b1;
      tick();
      rx_info = '0;
      await_hi(1'b1);
      for (k = 0; k < 20000 && jam_out === 1'b1; k++) tick();
      chk("jam_len", {16'h0, rows[i].len}, k);
    end
    speed_100 = 1'b1;
    jtry(4'h8, 5'h0C, 1'b1);
    jtry(4'h8, 5'h0A, 1'b0);
    jtry(4'h2, 5'h09, 1'b1);
    jtry(4'h2, 5'h0C, 1'b0);
    jtry(4'h1, 5'h10, 1'b1);
    rx_fill_bytes = 14'h003F;
    jtry(4'h4, 5'h0A, 1'b0);
    rx_fill_bytes = 14'h0040; tx_enable = 1'b0;
    jtry(4'h4, 5'h0A, 1'b0);
    full_duplex = 1'b1;
    tx_enable = 1'b1;
    jtry(4'h4, 5'h0A, 1'b0);
    // full duplex pause then zero pause; hi 2 units, lo 1 unit
    rx_fill_bytes = 14'h0080;
    tx_enable = 1'b0;
    wr(32'h00020101);
    repeat (10) tick();
    chk("pause_off", 32'h0, {31'h0, pause_req});
    tx_enable = 1'b1;
    await_hi(1'b0);
    chk("pause_t", 32'h0, {31'h0, pause_zero});
    repeat (10) tick();
    chk("paused", 32'h1, {31'h0, paused});
    chk("one_pause", 32'h0, {31'h0, pause_req});
    rx_fill_bytes = 14'h003F;
    await_hi(1'b0);
    chk("pause_z", 32'h1, {31'h0, pause_zero});
    repeat (10) tick();
    chk("unpaused", 32'h0, {31'h0, paused});
    // pause again, then a reset in mid-run must forget it
    rx_fill_bytes = 14'h0080;
    await_hi(1'b0);
    repeat (10) tick();
    chk("paused_2", 32'h1, {31'h0, paused});
    rst_n = 1'b0;
    repeat (2) tick();
    rst_n = 1'b1;
    chk("paused_rst", 32'h0, {31'h0, paused});
    chk("req_rst", 32'h0, {31'h0, pause_req});
    rdr(8'hAC);
    chk("cfg_rst2", 32'h0, rd);
    wrap_up();
  end
endmodule
`default_nettype wire
